// *** cps_power_switch.sv ***
// Power switch control: encodes the requested card supplies and drives the switch
// Assumes requests come from core_clk logic; the strap is an asynchronous pin
//
// Operation
// [RULE_01] Strap high at reset release selects the three-wire serial interface.
// [RULE_02] Strap low at reset release selects the four-wire parallel interface.
// [RULE_03] Switch-type select bit chooses between two switch encodings.
// [RULE_04] After reset the 1.8 V capable switch type is selected.
// [RULE_05] First type VPP: 00x 0V, 010 3.3V, 011 5V, 111 1.8V, else Hi-Z.
// [RULE_06] Second type VPP: 00x 0V, 010 3.3V, 011 5V, 10x 12V, 11x Hi-Z.
// [RULE_07] VCC bits: 00 0V, 01 3.3V, 10 5V, 11 0V; shutdown low Hi-Z.
// [RULE_08] Serial protocol and wiring are the same for both switch types.
// [RULE_09] Power control runs on a free-running 16 kHz tick, no bus clock.
// [RULE_10] Shift bits 0 to 10 out with a clock, then latch; resend on change.
`timescale 1ns/1ps
module cps_power_switch
  import cps_pkg::*;
#(
  // Core cycles per slow tick, minus one; only lowered to shorten simulation
  parameter logic [13:0] TICK_LAST = RING_DIV_LAST
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        global_reset_n,
  input  wire logic        switch_iface_strap,
  input  wire logic        switch_type_select,
  input  wire cps_req_t    supply_req,
  output cps_serial_t      serial_out,
  output cps_par_t         par_chan_a,
  output cps_par_t         par_chan_b,
  output logic             serial_mode,
  output logic             busy
);

  logic [1:0]       strap_sync;
  logic [1:0]       global_reset_n_sync;
  logic             global_reset_n_prev;
  logic [13:0]      div_cnt;
  logic             tick;
  logic [10:0]      next_word;
  logic [10:0]      sent_word;
  logic [10:0]      shift_word;
  logic [3:0]       bit_idx;
  logic             sw_type;
  logic             first_send;

  typedef enum logic [1:0] {
    CPS_IDLE  = 2'b00,
    CPS_DATA  = 2'b01,
    CPS_CLKHI = 2'b10,
    CPS_LATCH = 2'b11
  } cps_state_t;
  cps_state_t state;

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      strap_sync <= 2'h0;
      global_reset_n_sync  <= 2'h0;
      global_reset_n_prev  <= 1'b0;
    end else begin
      strap_sync <= {strap_sync[0], switch_iface_strap};
      global_reset_n_sync  <= {global_reset_n_sync[0], global_reset_n};
      global_reset_n_prev  <= global_reset_n_sync[1];
    end
  end

  // Interface select caught at rising edge of global reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      serial_mode <= 1'b0;
    end else if (global_reset_n_sync[1] && !global_reset_n_prev) begin
      serial_mode <= strap_sync[1]; // [RULE_01] [RULE_02]
    end
  end

  // Switch type, held at default while global reset is low
  always_ff @(posedge core_clk) begin
    if (srst || !global_reset_n_sync[1]) begin
      sw_type <= SW_TYPE_RESET; // [RULE_04]
    end else begin
      sw_type <= switch_type_select; // [RULE_03]
    end
  end

  // Slow tick standing in for the always-on ring oscillator
  always_ff @(posedge core_clk) begin
    if (srst) begin
      div_cnt <= 14'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_cnt == TICK_LAST); // [RULE_09]
      div_cnt <= (div_cnt == TICK_LAST) ? 14'h0 : div_cnt + 14'h1;
    end
  end

  // Encode requests into the switch control word
  always_comb begin
    next_word = 11'h0;
    next_word[B_SWITCH_SHUTDOWN_N] = 1'b1;
    unique case (supply_req.chan_a_core_supply) // [RULE_07]
      CPS_V_3V3: {next_word[B_A_VCC_HI], next_word[B_A_VCC_LO]} = 2'h1;
      CPS_V_5V:  {next_word[B_A_VCC_HI], next_word[B_A_VCC_LO]} = 2'h2;
      default:   {next_word[B_A_VCC_HI], next_word[B_A_VCC_LO]} = 2'h0;
    endcase
    unique case (supply_req.chan_b_core_supply) // [RULE_07]
      CPS_V_3V3: {next_word[B_B_VCC_HI], next_word[B_B_VCC_LO]} = 2'h1;
      CPS_V_5V:  {next_word[B_B_VCC_HI], next_word[B_B_VCC_LO]} = 2'h2;
      default:   {next_word[B_B_VCC_HI], next_word[B_B_VCC_LO]} = 2'h0;
    endcase
    {next_word[B_A_VPP0], next_word[B_A_VPP1], next_word[B_A_VPP2]} =
      vpp_code(supply_req.chan_a_prog_supply, sw_type);
    {next_word[B_B_VPP0], next_word[B_B_VPP1], next_word[B_B_VPP2]} =
      vpp_code(supply_req.chan_b_prog_supply, sw_type);
    if (supply_req.chan_a_core_supply == CPS_V_HIZ || supply_req.chan_b_core_supply == CPS_V_HIZ) begin
      next_word[B_SWITCH_SHUTDOWN_N] = 1'b0; // [RULE_07]
    end
  end

  // Code order is {D0/D4, D1/D5, D9/D10}
  function automatic logic [2:0] vpp_code(input cps_volt_t v, input logic second_type);
    logic [2:0] c;
    c = 3'h0;
    unique case (v)
      CPS_V_0:   c = 3'h0;
      CPS_V_3V3: c = 3'h2;
      CPS_V_5V:  c = 3'h3;
      CPS_V_12V: c = second_type ? 3'h4 : 3'h6; // [RULE_06]
      CPS_V_1V8: c = second_type ? 3'h6 : 3'h7; // [RULE_05]
      default:   c = 3'h6; // [RULE_05] [RULE_06]
    endcase
    return c;
  endfunction

  // Serial shifter, one step per slow tick
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state      <= CPS_IDLE;
      serial_out <= '0;
      shift_word <= 11'h0;
      sent_word  <= 11'h0;
      bit_idx    <= 4'h0;
      first_send <= 1'b1;
      busy       <= 1'b0;
    end else if (tick && serial_mode) begin
      unique case (state)
        CPS_IDLE: begin
          serial_out.latch <= 1'b0;
          if (next_word != sent_word || first_send) begin // [RULE_10]
            shift_word <= next_word;
            sent_word  <= next_word;
            first_send <= 1'b0;
            bit_idx    <= 4'h0;
            busy       <= 1'b1;
            state      <= CPS_DATA;
          end else begin
            busy <= 1'b0;
          end
        end
        CPS_DATA: begin
          serial_out.clk  <= 1'b0;
          serial_out.data <= shift_word[bit_idx]; // [RULE_08] [RULE_10]
          state           <= CPS_CLKHI;
        end
        CPS_CLKHI: begin
          serial_out.clk <= 1'b1;
          bit_idx        <= bit_idx + 4'h1;
          state          <= (bit_idx == CTRL_LAST_BIT) ? CPS_LATCH : CPS_DATA;
        end
        CPS_LATCH: begin
          serial_out.clk   <= 1'b0;
          serial_out.latch <= 1'b1; // [RULE_10]
          state            <= CPS_IDLE;
        end
      endcase
    end
  end

  // Parallel outputs, updated on the slow tick in parallel mode only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      par_chan_a <= '0;
      par_chan_b <= '0;
    end else if (tick && !serial_mode) begin
      par_chan_a.vcc <= {next_word[B_A_VCC_HI], next_word[B_A_VCC_LO]};
      par_chan_a.vpp <= {next_word[B_A_VPP0], next_word[B_A_VPP1]};
      par_chan_b.vcc <= {next_word[B_B_VCC_HI], next_word[B_B_VCC_LO]};
      par_chan_b.vpp <= {next_word[B_B_VPP0], next_word[B_B_VPP1]};
    end
  end

  a_strap_capture: assert property (@(posedge core_clk) disable iff (srst)
    (global_reset_n_sync[1] && !global_reset_n_prev) |=> serial_mode == $past(strap_sync[1])) // [RULE_01]
    else $error("strap not captured at reset release");
  a_strap_hold: assert property (@(posedge core_clk) disable iff (srst)
    !(global_reset_n_sync[1] && !global_reset_n_prev) |=> $stable(serial_mode)) // [RULE_02]
    else $error("interface mode changed outside reset release");
  a_type_default: assert property (@(posedge core_clk) disable iff (srst)
    !global_reset_n_sync[1] |=> sw_type == SW_TYPE_RESET) // [RULE_04]
    else $error("switch type not default during reset");
  a_type_follow: assert property (@(posedge core_clk) disable iff (srst)
    global_reset_n_sync[1] |=> sw_type == $past(switch_type_select)) // [RULE_03]
    else $error("switch type does not follow select");
  a_vpp_1v8: assert property (@(posedge core_clk) disable iff (srst)
    (!sw_type && supply_req.chan_a_prog_supply == CPS_V_1V8) |->
      {next_word[B_A_VPP0], next_word[B_A_VPP1], next_word[B_A_VPP2]} == 3'h7) // [RULE_05]
    else $error("wrong 1.8 V code");
  a_vpp_12v: assert property (@(posedge core_clk) disable iff (srst)
    (sw_type && supply_req.chan_b_prog_supply == CPS_V_12V) |->
      {next_word[B_B_VPP0], next_word[B_B_VPP1]} == 2'h2) // [RULE_06]
    else $error("wrong 12 V code");
  a_vcc_5v: assert property (@(posedge core_clk) disable iff (srst)
    supply_req.chan_a_core_supply == CPS_V_5V |->
      {next_word[B_A_VCC_HI], next_word[B_A_VCC_LO]} == 2'h2) // [RULE_07]
    else $error("wrong 5 V VCC code");
  a_tick_period: assert property (@(posedge core_clk) disable iff (srst)
    tick |=> !tick [*8]) // [RULE_09]
    else $error("slow tick too frequent");
  a_latch_after_shift: assert property (@(posedge core_clk) disable iff (srst)
    $rose(serial_out.latch) |-> $past(state) == CPS_LATCH && serial_mode) // [RULE_10] [RULE_08]
    else $error("latch without completed shift");

  // Idle tick that finds a new word to send
  sequence s_frame_start;
    tick && serial_mode && state == CPS_IDLE && (next_word != sent_word || first_send);
  endsequence
  a_busy_frame: assert property (@(posedge core_clk) disable iff (srst)
    s_frame_start |=> busy && state == CPS_DATA) // [RULE_10]
    else $error("frame start did not raise busy");

endmodule // cps_power_switch

// *** cps_pkg.sv ***
// Package for the card power switch control block
// Assumes a single 250 MHz core clock and synchronous reset
package cps_pkg;

  localparam int          CLK_FREQ_HZ      = 250_000_000;
  localparam int          RING_FREQ_HZ     = 16_000;
  // Cycles of core_clk per tick of the slow power-control clock
  localparam int          RING_DIV         = CLK_FREQ_HZ / RING_FREQ_HZ;
  localparam int          RING_DIV_W       = 14;
  localparam logic [13:0] RING_DIV_LAST    = 14'(RING_DIV - 1);

  localparam int          CTRL_W           = 11;
  localparam logic [3:0]  CTRL_LAST_BIT    = 4'ha;
  localparam logic        SW_TYPE_RESET    = 1'b0;

  // Control word bit positions
  localparam int          B_A_VPP0         = 0;
  localparam int          B_A_VPP1         = 1;
  localparam int          B_A_VCC_LO       = 2;
  localparam int          B_A_VCC_HI       = 3;
  localparam int          B_B_VPP0         = 4;
  localparam int          B_B_VPP1         = 5;
  localparam int          B_B_VCC_HI       = 6;
  localparam int          B_B_VCC_LO       = 7;
  localparam int          B_SWITCH_SHUTDOWN_N           = 8;
  localparam int          B_A_VPP2         = 9;
  localparam int          B_B_VPP2         = 10;

  // Requested supply levels
  typedef enum logic [2:0] {
    CPS_V_0    = 3'h0,
    CPS_V_3V3  = 3'h1,
    CPS_V_5V   = 3'h2,
    CPS_V_12V  = 3'h3,
    CPS_V_1V8  = 3'h4,
    CPS_V_HIZ  = 3'h5
  } cps_volt_t;

  typedef struct packed {
    cps_volt_t chan_a_core_supply;
    cps_volt_t chan_a_prog_supply;
    cps_volt_t chan_b_core_supply;
    cps_volt_t chan_b_prog_supply;
  } cps_req_t;

  typedef struct packed {
    logic clk;
    logic data;
    logic latch;
  } cps_serial_t;

  typedef struct packed {
    logic [1:0] vcc;
    logic [1:0] vpp;
  } cps_par_t;

  localparam cps_req_t REQ_RESET = '{CPS_V_0, CPS_V_0, CPS_V_0, CPS_V_0};

endpackage

// *** cps_switch_model.sv ***
// Behavioural serial power switch: shifts in control bits and applies them on latch
// Assumes its serial pins come from the power switch control block
`timescale 1ns/1ps
module cps_switch_model
  import cps_pkg::*;
(
  input  cps_serial_t serial_in,
  output logic [10:0] word,
  output logic [4:0]  nbits,
  output int          nwords
);
  logic [10:0] shreg;
  int          tot;
  int          last;

  initial begin
    shreg = '0;
    tot = 0;
    last = 0;
    word = '0;
    nbits = '0;
    nwords = 0;
  end

  // Bits arrive LSB first, one per clock rise, same wiring for both types
  always @(posedge serial_in.clk) begin
    shreg <= {serial_in.data, shreg[10:1]};
    tot <= tot + 1;
  end

  // Latch applies the shifted word and records how many bits came in
  always @(posedge serial_in.latch) begin
    word <= shreg;
    nbits <= 5'(tot - last);
    last <= tot;
    nwords <= nwords + 1;
  end
endmodule // cps_switch_model

// *** testbench.sv ***
// Testbench for the card power switch control block
// Assumes a 250 MHz core clock and a serial switch model on the serial pins
`timescale 1ns/1ps
module testbench
  import cps_pkg::*;
;
  // Short slow tick so that serial frames fit the run
  localparam logic [13:0] TB_TICK_LAST = 14'hf;
  localparam int          TICK_CYC     = 16;

  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        global_reset_n_n = 1'b0;
  logic        strap = 1'b0;
  logic        sw_type = 1'b0;
  cps_req_t    req = REQ_RESET;
  cps_serial_t ser_o;
  cps_par_t    par_a;
  cps_par_t    par_b;
  logic        ser_mode;
  logic        busy;
  logic [10:0] w;
  logic [4:0]  nbits;
  int          nwords;
  int          mismatches = 0;
  int          n_tests = 0;

  always #2 core_clk = ~core_clk;

  cps_power_switch #(.TICK_LAST(TB_TICK_LAST)) uut (.core_clk(core_clk), .srst(srst), .global_reset_n(global_reset_n_n),
    .switch_iface_strap(strap), .switch_type_select(sw_type), .supply_req(req),
    .serial_out(ser_o), .par_chan_a(par_a), .par_chan_b(par_b), .serial_mode(ser_mode), .busy(busy));
  cps_switch_model sw (.serial_in(ser_o), .word(w), .nbits(nbits), .nwords(nwords));

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic cps_volt_t dvpp(logic sh, logic d0, logic d1, logic d2, logic t);
    if (!sh) return CPS_V_HIZ;
    case ({d0, d1})
      2'b00: return CPS_V_0;
      2'b01: return d2 ? CPS_V_5V : CPS_V_3V3;
      2'b10: return t ? CPS_V_12V : CPS_V_HIZ;
      default: return (d2 && !t) ? CPS_V_1V8 : CPS_V_HIZ;
    endcase
  endfunction

  function automatic cps_volt_t dvcc(logic sh, logic hi, logic lo);
    if (!sh) return CPS_V_HIZ;
    case ({hi, lo})
      2'b01: return CPS_V_3V3;
      2'b10: return CPS_V_5V;
      default: return CPS_V_0;
    endcase
  endfunction

  // Pulse the global reset pin with the strap at the given level
  task automatic glob(logic s);
    global_reset_n_n = 1'b0;
    strap = s;
    cyc(10);
    global_reset_n_n = 1'b1;
    cyc(8);
    chk("serial_mode", 12'(ser_mode), 12'(s));
  endtask

  // Request supplies, wait until a word is latched and the sender is idle, decode it
  task automatic ser(logic t, cps_req_t r, cps_req_t exp);
    int n;
    cps_req_t got;
    n = nwords;
    sw_type = t;
    req = r;
    for (int i = 0; i < 2000 && (nwords == n || busy); i++) cyc(1);
    chk("word_latched", 12'(nwords != n && !busy), 12'h001);
    got = '{dvcc(w[8], w[3], w[2]), dvpp(w[8], w[0], w[1], w[9], t),
            dvcc(w[8], w[6], w[7]), dvpp(w[8], w[4], w[5], w[10], t)};
    chk("supply_word", got, exp);
    chk("bit_count", 12'(nbits), 12'h00b);
    $display("Serial word test done");
  endtask

  initial begin
    cyc(5);
    srst = 1'b0;
    glob(1'b0);
    req = '{CPS_V_3V3, CPS_V_5V, CPS_V_5V, CPS_V_0};
    cyc(2 * TICK_CYC + 50);
    chk("parallel_pins", 12'({par_a, par_b}), 12'h058);
    chk("busy_parallel", 12'(busy), 12'h000);
    $display("Parallel test done");
    glob(1'b1);
    ser(1'b0, '{CPS_V_3V3, CPS_V_1V8, CPS_V_5V, CPS_V_3V3},
              '{CPS_V_3V3, CPS_V_1V8, CPS_V_5V, CPS_V_3V3});
    ser(1'b1, '{CPS_V_0, CPS_V_12V, CPS_V_3V3, CPS_V_1V8},
              '{CPS_V_0, CPS_V_12V, CPS_V_3V3, CPS_V_HIZ});
    ser(1'b0, '{CPS_V_5V, CPS_V_12V, CPS_V_0, CPS_V_0},
              '{CPS_V_5V, CPS_V_HIZ, CPS_V_0, CPS_V_0});
    ser(1'b1, '{CPS_V_HIZ, CPS_V_5V, CPS_V_5V, CPS_V_5V},
              '{CPS_V_HIZ, CPS_V_HIZ, CPS_V_HIZ, CPS_V_HIZ});
    chk("parallel_hold", 12'({par_a, par_b}), 12'h058);
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
endmodule // testbench
